//--- logic/move_ops_pkg.sv
// Constants and types for the move and return instruction unit
package move_ops_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BANK_W = 5;
    localparam int unsigned LATCH_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FILE_W = 7;
    localparam int unsigned PTR_W = 16;
    localparam int unsigned PC_W = 15;
    localparam int unsigned OFS_W = 6;
    localparam int unsigned RADDR_W = 4;
    localparam int unsigned IRQ_ENABLE_BIT = 7;
    localparam int unsigned SOFT_RESET_BIT = 2;
    // Indirect port file addresses inside every bank
    localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
    localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
    // Register map, word per index
    localparam logic [3:0] REG_BANK = 4'h0;
    localparam logic [3:0] REG_LATCH = 4'h1;
    localparam logic [3:0] REG_ACC = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_PTR0_LO = 4'h4;
    localparam logic [3:0] REG_PTR0_HI = 4'h5;
    localparam logic [3:0] REG_PTR1_LO = 4'h6;
    localparam logic [3:0] REG_PTR1_HI = 4'h7;
    localparam logic [3:0] REG_IRQ_CTRL = 4'h8;
    localparam logic [3:0] REG_PWR_CTRL = 4'h9;
    localparam logic [3:0] REG_PC_LO = 4'hA;
    localparam logic [3:0] REG_PC_HI = 4'hB;
    // Reset values and the pointer step of one
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [14:0] PC_RST = 15'h0000;
    localparam logic [7:0] PWR_RST = 8'h04;
    localparam logic [15:0] PTR_ONE = 16'h0001;
    typedef enum logic [2:0] {
        OP_IDLE = 3'b000,
        OP_BANK_LIT = 3'b001,
        OP_LATCH_LIT = 3'b010,
        OP_ACC_LIT = 3'b011,
        OP_STORE_ACC = 3'b100,
        OP_IND_STORE = 3'b101,
        OP_SOFT_RESET = 3'b110,
        OP_IRQ_RETURN = 3'b111
    } op_t;
    typedef enum logic [1:0] {
        MODE_PRE_INC = 2'b00,
        MODE_PRE_DEC = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } upd_mode_t;
    typedef enum logic {
        ST_READY = 1'b0,
        ST_RET_SECOND = 1'b1
    } exec_state_t;
endpackage

//--- logic/move_ops_unit.sv
// Execution unit for literal moves, stores, indirect store and returns
`timescale 1ns/1ps
`default_nettype none
module move_ops_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire move_ops_pkg::op_t op_code,
    input wire logic [7:0] op_literal,
    input wire logic [6:0] op_file_addr,
    input wire logic op_ptr_sel,
    input wire logic op_relative,
    input wire move_ops_pkg::upd_mode_t pointer_update_mode,
    input wire logic [5:0] op_offset,
    output logic op_ready,
    input wire logic [14:0] stack_top,
    output logic stack_pop,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic dev_reset_out,
    output logic [14:0] pc,
    output logic global_irq_enable,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    move_ops_pkg::exec_state_t state_r, state_nxt;
    logic [4:0] bank_select_r;
    logic [6:0] upper_program_counter_latch_r;
    logic [7:0] acc_r;
    logic [7:0] status_r;
    logic [15:0] file_select_pointer_r [2];
    logic [7:0] irq_control_reg_r;
    logic [7:0] power_control_reg_r;
    logic [14:0] pc_r;
    logic pop_r, we_r, soft_rst_r;
    logic [15:0] addr_r;
    logic [7:0] wdata_r, rdata_r;

    wire accept = op_valid && (state_r == move_ops_pkg::ST_READY) && !soft_rst_r;
    wire do_op_bank = accept && (op_code == move_ops_pkg::OP_BANK_LIT);
    wire do_op_latch = accept && (op_code == move_ops_pkg::OP_LATCH_LIT);
    wire do_op_acc = accept && (op_code == move_ops_pkg::OP_ACC_LIT);
    wire do_op_store = accept && (op_code == move_ops_pkg::OP_STORE_ACC);
    wire do_op_ind = accept && (op_code == move_ops_pkg::OP_IND_STORE);
    wire do_op_soft = accept && (op_code == move_ops_pkg::OP_SOFT_RESET);
    wire do_op_ret = accept && (op_code == move_ops_pkg::OP_IRQ_RETURN);

    // Pointer arithmetic, plain 16-bit wrap
    wire [15:0] sel_ptr = file_select_pointer_r[op_ptr_sel];
    wire [15:0] ptr_inc = sel_ptr + move_ops_pkg::PTR_ONE;
    wire [15:0] ptr_dec = sel_ptr - move_ops_pkg::PTR_ONE;
    wire [15:0] ofs_ext = {{10{op_offset[5]}}, op_offset};
    wire [15:0] ptr_rel = sel_ptr + ofs_ext;
    wire mode_inc = !pointer_update_mode[0];
    wire mode_pre = !pointer_update_mode[1];
    wire [15:0] ptr_stepped = mode_inc ? ptr_inc : ptr_dec;
    wire [15:0] ind_addr = op_relative ? ptr_rel : (mode_pre ? ptr_stepped : sel_ptr);
    wire [15:0] ind_ptr_new = op_relative ? sel_ptr : ptr_stepped;

    wire direct_ind0 = (op_file_addr == move_ops_pkg::INDIRECT0_ADDR);
    wire direct_ind1 = (op_file_addr == move_ops_pkg::INDIRECT1_ADDR);
    wire [15:0] direct_addr = {4'h0, bank_select_r, op_file_addr};
    wire [15:0] store_addr = direct_ind0 ? file_select_pointer_r[0] :
                             direct_ind1 ? file_select_pointer_r[1] : direct_addr;

    // Bus write decode
    wire bw_bank = reg_wr && (reg_addr == move_ops_pkg::REG_BANK);
    wire bw_latch = reg_wr && (reg_addr == move_ops_pkg::REG_LATCH);
    wire bw_acc = reg_wr && (reg_addr == move_ops_pkg::REG_ACC);
    wire bw_status = reg_wr && (reg_addr == move_ops_pkg::REG_STATUS);
    wire bw_irq = reg_wr && (reg_addr == move_ops_pkg::REG_IRQ_CTRL);
    wire bw_pwr = reg_wr && (reg_addr == move_ops_pkg::REG_PWR_CTRL);
    wire [1:0] bw_ptr_lo;
    wire [1:0] bw_ptr_hi;
    assign bw_ptr_lo[0] = reg_wr && (reg_addr == move_ops_pkg::REG_PTR0_LO);
    assign bw_ptr_hi[0] = reg_wr && (reg_addr == move_ops_pkg::REG_PTR0_HI);
    assign bw_ptr_lo[1] = reg_wr && (reg_addr == move_ops_pkg::REG_PTR1_LO);
    assign bw_ptr_hi[1] = reg_wr && (reg_addr == move_ops_pkg::REG_PTR1_HI);

    wire [7:0] rd_mux =
        (reg_addr == move_ops_pkg::REG_BANK) ? {3'h0, bank_select_r} :
        (reg_addr == move_ops_pkg::REG_LATCH) ? {1'h0, upper_program_counter_latch_r} :
        (reg_addr == move_ops_pkg::REG_ACC) ? acc_r :
        (reg_addr == move_ops_pkg::REG_STATUS) ? status_r :
        (reg_addr == move_ops_pkg::REG_PTR0_LO) ? file_select_pointer_r[0][7:0] :
        (reg_addr == move_ops_pkg::REG_PTR0_HI) ? file_select_pointer_r[0][15:8] :
        (reg_addr == move_ops_pkg::REG_PTR1_LO) ? file_select_pointer_r[1][7:0] :
        (reg_addr == move_ops_pkg::REG_PTR1_HI) ? file_select_pointer_r[1][15:8] :
        (reg_addr == move_ops_pkg::REG_IRQ_CTRL) ? irq_control_reg_r :
        (reg_addr == move_ops_pkg::REG_PWR_CTRL) ? power_control_reg_r :
        (reg_addr == move_ops_pkg::REG_PC_LO) ? pc_r[7:0] :
        (reg_addr == move_ops_pkg::REG_PC_HI) ? {1'h0, pc_r[14:8]} : 8'h00;

    // Soft reset acts like the pin one cycle after the op, except on power control and read data
    wire rst_all = rst || soft_rst_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            move_ops_pkg::ST_READY: begin
                if (do_op_ret) begin
                    state_nxt = move_ops_pkg::ST_RET_SECOND;
                end
            end
            move_ops_pkg::ST_RET_SECOND: begin
                state_nxt = move_ops_pkg::ST_READY;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            state_r <= move_ops_pkg::ST_READY;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            bank_select_r <= move_ops_pkg::DATA_RST[4:0];
            upper_program_counter_latch_r <= move_ops_pkg::DATA_RST[6:0];
            acc_r <= move_ops_pkg::DATA_RST;
        end else begin
            if (do_op_bank) begin
                bank_select_r <= op_literal[4:0];
            end else if (bw_bank) begin
                bank_select_r <= reg_wdata[4:0];
            end
            if (do_op_latch) begin
                upper_program_counter_latch_r <= op_literal[6:0];
            end else if (bw_latch) begin
                upper_program_counter_latch_r <= reg_wdata[6:0];
            end
            if (do_op_acc) begin
                acc_r <= op_literal;
            end else if (bw_acc) begin
                acc_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            status_r <= move_ops_pkg::DATA_RST;
        end else if (bw_status) begin
            status_r <= reg_wdata;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ptr
            wire upd = do_op_ind && (op_ptr_sel == 1'(gi));
            always_ff @(posedge clk) begin
                if (rst_all) begin
                    file_select_pointer_r[gi] <= move_ops_pkg::PTR_RST;
                end else if (upd) begin
                    file_select_pointer_r[gi] <= ind_ptr_new;
                end else if (bw_ptr_lo[gi]) begin
                    file_select_pointer_r[gi][7:0] <= reg_wdata;
                end else if (bw_ptr_hi[gi]) begin
                    file_select_pointer_r[gi][15:8] <= reg_wdata;
                end
            end
        end
    endgenerate

    // return loads PC and enables irqs
    always_ff @(posedge clk) begin
        if (rst_all) begin
            pc_r <= move_ops_pkg::PC_RST;
            irq_control_reg_r <= move_ops_pkg::DATA_RST;
            pop_r <= 1'b0;
        end else begin
            pop_r <= do_op_ret;
            if (do_op_ret) begin
                pc_r <= stack_top;
            end
            if (bw_irq) begin
                irq_control_reg_r <= reg_wdata;
            end
            // Hardware set wins over a same-cycle software clear
            if (do_op_ret) begin
                irq_control_reg_r[move_ops_pkg::IRQ_ENABLE_BIT] <= 1'b1;
            end
        end
    end

    // soft reset pulse and flag clear
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_rst_r <= 1'b0;
            power_control_reg_r <= move_ops_pkg::PWR_RST;
        end else begin
            soft_rst_r <= do_op_soft;
            if (bw_pwr) begin
                power_control_reg_r <= reg_wdata;
            end
            if (soft_rst_r) begin
                power_control_reg_r[move_ops_pkg::SOFT_RESET_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            we_r <= 1'b0;
            addr_r <= move_ops_pkg::PTR_RST;
            wdata_r <= move_ops_pkg::DATA_RST;
        end else begin
            we_r <= do_op_store || do_op_ind;
            if (do_op_store) begin
                addr_r <= store_addr;
                wdata_r <= acc_r;
            end else if (do_op_ind) begin
                addr_r <= ind_addr;
                wdata_r <= acc_r;
            end
        end
    end

    // Read data stays valid through a soft reset
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= move_ops_pkg::DATA_RST;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= move_ops_pkg::DATA_RST;
        end
    end

    // ready unless in second return cycle or soft reset pulse
    assign op_ready = (state_r == move_ops_pkg::ST_READY) && !soft_rst_r;
    assign stack_pop = pop_r;
    assign mem_we = we_r;
    assign mem_addr = addr_r;
    assign mem_wdata = wdata_r;
    assign dev_reset_out = soft_rst_r;
    assign pc = pc_r;
    assign global_irq_enable = irq_control_reg_r[move_ops_pkg::IRQ_ENABLE_BIT];
    assign reg_rdata = rdata_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_BANK_LOAD: assert property (do_op_bank && !soft_rst_r |=>
        bank_select_r == $past(op_literal[4:0])) else $error("bank load wrong");
    AST_LATCH_LOAD: assert property (do_op_latch |=>
        upper_program_counter_latch_r == $past(op_literal[6:0])) else $error("latch load wrong");
    AST_ACC_LOAD: assert property (do_op_acc |=> acc_r == $past(op_literal))
        else $error("accumulator load wrong");
    AST_STORE_DATA: assert property (do_op_store |=> mem_we && mem_wdata == $past(acc_r))
        else $error("store data wrong");
    AST_IND_POSTINC: assert property (do_op_ind && !op_relative
        && pointer_update_mode == move_ops_pkg::MODE_POST_INC |=>
        mem_addr == $past(sel_ptr) && file_select_pointer_r[$past(op_ptr_sel)] ==
        $past(sel_ptr) + move_ops_pkg::PTR_ONE) else $error("post increment wrong");
    AST_REL_KEEP: assert property (do_op_ind && op_relative |=>
        file_select_pointer_r[$past(op_ptr_sel)] == $past(sel_ptr))
        else $error("relative form moved pointer");
    AST_INDIRECT_REDIRECT: assert property (do_op_store && direct_ind1 |=>
        mem_addr == $past(file_select_pointer_r[1])) else $error("redirect wrong");
    AST_PTR_WRAP: assert property (do_op_ind && !op_relative && sel_ptr == 16'hFFFF
        && pointer_update_mode == move_ops_pkg::MODE_POST_INC |=>
        file_select_pointer_r[$past(op_ptr_sel)] == 16'h0000) else $error("no wrap");
    AST_STATUS_KEEP: assert property (!bw_status && !soft_rst_r |=> $stable(status_r))
        else $error("status changed");
    AST_SOFT_RESET: assert property (do_op_soft |=> dev_reset_out ##1
        !power_control_reg_r[move_ops_pkg::SOFT_RESET_BIT] && acc_r == move_ops_pkg::DATA_RST)
        else $error("soft reset wrong");
    AST_RET_PC: assert property (do_op_ret |=> stack_pop && pc == $past(stack_top))
        else $error("return pc wrong");
    AST_RET_IRQ_EN: assert property (do_op_ret |=> global_irq_enable)
        else $error("irq enable not set");
    AST_RET_TWO: assert property (do_op_ret |=> !op_ready ##1 op_ready)
        else $error("return not two cycles");
    AST_ONE_CYCLE: assert property (accept && op_code != move_ops_pkg::OP_IRQ_RETURN
        && op_code != move_ops_pkg::OP_SOFT_RESET |=> op_ready) else $error("op stalled");

    COV_IND_STORE: cover property (do_op_ind ##1 mem_we);
    COV_RETURN: cover property (do_op_ret ##2 op_ready);
    COV_SOFT: cover property (do_op_soft ##1 dev_reset_out);
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the move and return instruction unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk;
    logic rst;
    logic op_valid;
    move_ops_pkg::op_t op_code;
    logic [7:0] op_literal;
    logic [6:0] op_file_addr;
    logic op_ptr_sel;
    logic op_relative;
    move_ops_pkg::upd_mode_t pointer_update_mode;
    logic [5:0] op_offset;
    logic op_ready;
    logic [14:0] stack_top;
    logic stack_pop;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic dev_reset_out;
    logic [14:0] pc;
    logic global_irq_enable;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    int fail_count;
    int n_compared;
    // Pointer one starts at FFFF, so every mode steps across the wrap point
    logic [15:0] ea [4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
    logic [15:0] pe [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};

    move_ops_unit move_ops_unit_inst (
        .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .op_literal(op_literal), .op_file_addr(op_file_addr), .op_ptr_sel(op_ptr_sel),
        .op_relative(op_relative), .pointer_update_mode(pointer_update_mode),
        .op_offset(op_offset), .op_ready(op_ready), .stack_top(stack_top),
        .stack_pop(stack_pop), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .dev_reset_out(dev_reset_out), .pc(pc), .global_irq_enable(global_irq_enable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        rd(a, d);
        chk(name, {8'h00, d}, {8'h00, exp});
    endtask

    task automatic ptrchk(input logic sel, input logic [15:0] exp);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(sel ? move_ops_pkg::REG_PTR1_LO : move_ops_pkg::REG_PTR0_LO, lo);
        rd(sel ? move_ops_pkg::REG_PTR1_HI : move_ops_pkg::REG_PTR0_HI, hi);
        chk("pointer", {hi, lo}, exp);
    endtask

    // Ready is looked at 1 ns after the clock edge, where it has settled
    task automatic op(input move_ops_pkg::op_t c, input logic [7:0] lit = 8'h00,
            input logic [6:0] f = 7'h00, input logic ps = 1'b0, input logic rel = 1'b0,
            input move_ops_pkg::upd_mode_t m = move_ops_pkg::MODE_PRE_INC,
            input logic [5:0] ofs = 6'h00);
        int k;
        for (k = 0; k < 8 && op_ready !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 8) begin
            fail_count++;
            report_and_stop();
        end else begin
            @(posedge clk);
            op_valid <= 1'b1;
            op_code <= c;
            op_literal <= lit;
            op_file_addr <= f;
            op_ptr_sel <= ps;
            op_relative <= rel;
            pointer_update_mode <= m;
            op_offset <= ofs;
            @(posedge clk);
            op_valid <= 1'b0;
            #1;
        end
    endtask

    initial begin
        int i;
        fail_count = 0;
        n_compared = 0;
        rst = 1'b1;
        op_valid = 1'b0;
        op_code = move_ops_pkg::OP_IDLE;
        op_literal = 8'h00;
        op_file_addr = 7'h00;
        op_ptr_sel = 1'b0;
        op_relative = 1'b0;
        pointer_update_mode = move_ops_pkg::MODE_PRE_INC;
        op_offset = 6'h00;
        stack_top = 15'h0000;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 16; i++) begin
            rdchk(4'(i), (i == 9) ? 8'h04 : 8'h00, "reset value");
        end
        wr(move_ops_pkg::REG_STATUS, 8'hA5);
        op(move_ops_pkg::OP_BANK_LIT, 8'hFF);
        rdchk(move_ops_pkg::REG_BANK, 8'h1F, "bank");
        op(move_ops_pkg::OP_LATCH_LIT, 8'hFF);
        rdchk(move_ops_pkg::REG_LATCH, 8'h7F, "latch");
        op(move_ops_pkg::OP_ACC_LIT, 8'h5A);
        rdchk(move_ops_pkg::REG_ACC, 8'h5A, "acc");
        op(move_ops_pkg::OP_STORE_ACC, 8'h00, 7'h7F);
        chk("store we", {15'h0000, mem_we}, 16'h0001);
        chk("store addr", mem_addr, 16'h0FFF);
        chk("store data", {8'h00, mem_wdata}, 16'h005A);
        @(posedge clk);
        #1;
        chk("store we end", {15'h0000, mem_we}, 16'h0000);
        op(move_ops_pkg::OP_IDLE);
        chk("idle we", {15'h0000, mem_we}, 16'h0000);
        rdchk(move_ops_pkg::REG_ACC, 8'h5A, "idle acc");
        wr(move_ops_pkg::REG_PTR1_LO, 8'hFF);
        wr(move_ops_pkg::REG_PTR1_HI, 8'hFF);
        wr(move_ops_pkg::REG_PTR0_LO, 8'h10);
        wr(move_ops_pkg::REG_PTR0_HI, 8'h00);
        for (i = 0; i < 4; i++) begin
            op(move_ops_pkg::OP_IND_STORE, 8'h00, 7'h00, 1'b1, 1'b0,
                move_ops_pkg::upd_mode_t'(i));
            chk("ind addr", mem_addr, ea[i]);
            chk("ind data", {7'h00, mem_we, mem_wdata}, 16'h015A);
            ptrchk(1'b1, pe[i]);
        end
        ptrchk(1'b0, 16'h0010);
        op(move_ops_pkg::OP_IND_STORE, 8'h00, 7'h00, 1'b0, 1'b1,
            move_ops_pkg::MODE_POST_INC, 6'h20);
        chk("rel low", mem_addr, 16'hFFF0);
        op(move_ops_pkg::OP_IND_STORE, 8'h00, 7'h00, 1'b0, 1'b1,
            move_ops_pkg::MODE_POST_DEC, 6'h1F);
        chk("rel high", mem_addr, 16'h002F);
        ptrchk(1'b0, 16'h0010);
        op(move_ops_pkg::OP_STORE_ACC, 8'h00, 7'h01);
        chk("port1 addr", mem_addr, 16'hFFFF);
        op(move_ops_pkg::OP_STORE_ACC, 8'h00, 7'h00);
        chk("port0 addr", mem_addr, 16'h0010);
        rdchk(move_ops_pkg::REG_STATUS, 8'hA5, "status");
        @(posedge clk);
        stack_top <= 15'h4321;
        wr(move_ops_pkg::REG_IRQ_CTRL, 8'h00);
        op(move_ops_pkg::OP_IRQ_RETURN);
        chk("pop", {15'h0000, stack_pop}, 16'h0001);
        chk("pc", {1'b0, pc}, 16'h4321);
        chk("irq enable", {15'h0000, global_irq_enable}, 16'h0001);
        chk("ret busy", {15'h0000, op_ready}, 16'h0000);
        @(posedge clk);
        #1;
        chk("ret done", {14'h0000, op_ready, stack_pop}, 16'h0002);
        rdchk(move_ops_pkg::REG_IRQ_CTRL, 8'h80, "irq ctrl");
        rdchk(move_ops_pkg::REG_PC_HI, 8'h43, "pc hi");
        op(move_ops_pkg::OP_SOFT_RESET);
        chk("dev reset", {14'h0000, dev_reset_out, op_ready}, 16'h0002);
        rdchk(move_ops_pkg::REG_PWR_CTRL, 8'h00, "soft flag");
        rdchk(move_ops_pkg::REG_ACC, 8'h00, "acc after reset");
        report_and_stop();
    end
endmodule
`default_nettype wire
